// [rtl/qpf_errflag.sv]
// Purpose: Acknowledged error flag
// Assumes: Fault input already synchronised
// Notes:   Set wins over clear
`timescale 1ns/1ps
module qpf_errflag
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic fault,
    input  wire logic ack,
    input  wire logic track,
    output logic      flag_q
);
    logic flag_d;

    always_comb
    begin
        flag_d = fault | (flag_q & ~ack & ~track); // R4 R5 R7
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            flag_q <= 1'b0;
        else if (ce)
            flag_q <= flag_d;
    end

endmodule : qpf_errflag

// [rtl/qpf_sync2.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module qpf_sync2
#(
    parameter int W = 1
)
(
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce)
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule : qpf_sync2

// [rtl/qpf_top.sv]
// Purpose: Quadrature position counter channel with APB control
// Assumes: Encoder tracks and faults arrive asynchronously on pins
// Notes:   Handshake latency is counted in system clock cycles
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Function
// R1 - Controller never asserts both loads together
// R2 - Load fault holds until requests cleared
// R3 - Isochronous handshakes take 4 or 6 cycles
// R4 - Fault sets error flag, detection continues
// R5 - Error clears after cause gone and acknowledge
// R6 - Parameter fault cleared only by valid parameters
// R7 - Acknowledge held or stopped: flags track faults
// R8 - Diagnostic reports only with group diagnostics
// R9 - Edge evaluation single, double or quadruple
// R10 - Stop response: turn off or continue
// R11 - Gate polarity; inverted needs hardware gate
// R12 - Auxiliary input function selection
// R13 - Periodic sync only for sync function
// R14 - Multiple evaluation needs quadrature encoder
// R15 - Single: A edges counted while B low
// R16 - Double: both A edges, direction from B
// R17 - Quadruple: all edges, direction from A,B
// R18 - Tracks up to 500 kHz accepted
// R19 - Status clear by request and active handshake
// R20 - Multiple requests in one write: load fault
// R21 - Sync done held until status clear
// R22 - Count pulse steps counter same cycle
module qpf_top
    import qpf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        auxiliary_input,
    input  wire logic        supply_short_in,
    input  wire logic        enc_fault_in,
    output logic             diag_event_q
);
    logic [4:0]  pin_s;
    logic        a_s, b_s, aux_s, sup_s, enf_s;
    logic        a_p_q, b_p_q, aux_p_q;
    qpf_ctrl_s   ctrl_q, ctrl_d, ctrl_p_q;
    qpf_param_s  par_q, par_d;
    logic [31:0] ldval_q, ldval_d, staged_q, staged_d;
    logic [31:0] cnt_q, cnt_d, latch_q, latch_d;
    logic        load_fault_q, load_fault_d, param_fault_q, param_fault_d;
    logic        clr_act_q, clr_act_d, sync_done_q, sync_done_d;
    logic        load_ack_q, load_ack_d, up_q, up_d, dn_q, dn_d;
    logic        gate_p_q, diag_d;
    logic [2:0]  clr_cnt_q, clr_cnt_d, ld_cnt_q, ld_cnt_d, lat;
    logic        supply_short_flag, enc_fault_flag, err_p_q;
    logic        wr_en, acc, ctrl_wr, par_wr, stopped, turned_off;
    logic        gate_open, up_pulse, down_pulse, up_raw, dn_raw;
    logic        aux_rise, sync_ev, retrig_ev, gate_rise, ld_apply;
    logic        par_bad, multi_req, one_req, ld_rise;
    logic [4:0]  req_v;
    logic [31:0] rd_d;
    logic        rd_err;

    qpf_sync2 #(.W(5)) u_sync ( // R18
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .async_in ({enc_a, enc_b, auxiliary_input, supply_short_in,
                    enc_fault_in}),
        .sync_q   (pin_s)
    );
    assign {a_s, b_s, aux_s, sup_s, enf_s} = pin_s;

    qpf_errflag u_sup_flag (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .fault   (sup_s),
        .ack     (ctrl_q.fault_acknowledge),
        .track   (stopped),
        .flag_q  (supply_short_flag)
    );

    qpf_errflag u_enc_flag (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .fault   (enf_s),
        .ack     (ctrl_q.fault_acknowledge),
        .track   (stopped),
        .flag_q  (enc_fault_flag)
    );

    // APB decode: answer on second access cycle
    assign acc     = psel & penable & pready;
    assign wr_en   = acc & pwrite;
    assign ctrl_wr = wr_en && paddr == ADDR_CTRL;
    assign par_wr  = wr_en && paddr == ADDR_PARAM;

    assign stopped    = ctrl_q.ctrl_stop;
    assign turned_off = stopped & ~par_q.stop_continue; // R10
    assign req_v = pwdata[4:0];
    assign multi_req = ctrl_wr && (req_v & (req_v - 5'h01)) != 5'h00;
    assign one_req   = ctrl_wr && req_v != 5'h00 && !multi_req;
    assign lat = par_q.iso_mode ? (par_q.iso_long ? LAT_ISO6 : LAT_ISO4)
                                : LAT_PLAIN; // R3

    // Edge evaluation
    always_comb
    begin
        up_raw = 1'b0;
        dn_raw = 1'b0;
        unique case (par_q.eval) // R9
            EV_SINGLE:
            begin
                up_raw = a_s & ~a_p_q & ~b_s; // R15
                dn_raw = ~a_s & a_p_q & ~b_s; // R15
            end
            EV_DOUBLE:
            begin
                up_raw = (a_s ^ a_p_q) & (a_s ^ b_s); // R16
                dn_raw = (a_s ^ a_p_q) & ~(a_s ^ b_s); // R16
            end
            EV_QUAD:
            begin
                up_raw = ((a_s ^ a_p_q) | (b_s ^ b_p_q)) & (a_s ^ b_p_q);
                dn_raw = ((a_s ^ a_p_q) | (b_s ^ b_p_q)) & (b_s ^ a_p_q);
            end // R17
            default:
            begin
                up_raw = 1'b0;
                dn_raw = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        gate_open = ctrl_q.sw_gate & ~turned_off;
        if (par_q.di_fn == DI_HW_GATE)
            gate_open = gate_open & (aux_s ^ par_q.gate_inv); // R11
        up_pulse   = gate_open & (par_q.dir_invert ? dn_raw : up_raw);
        down_pulse = gate_open & (par_q.dir_invert ? up_raw : dn_raw);
        aux_rise   = aux_s & ~aux_p_q;
        gate_rise  = gate_open & ~gate_p_q & ~par_q.gate_interrupt;
        retrig_ev  = aux_rise && par_q.di_fn == DI_LATCH_RT; // R12
        sync_ev    = aux_rise && par_q.di_fn == DI_SYNC
                     && (par_q.sync_periodic || !sync_done_q); // R13
        ld_apply   = ld_cnt_q == 3'h1 && ctrl_q.direct_load_request;
        ld_rise    = (ctrl_q.direct_load_request
                      & ~ctrl_p_q.direct_load_request)
                     | (ctrl_q.staged_load_request
                        & ~ctrl_p_q.staged_load_request);
    end

    // Counter, load, latch
    always_comb
    begin
        cnt_d    = cnt_q;
        staged_d = staged_q;
        latch_d  = latch_q;
        if (ld_apply)
            cnt_d = ldval_q;
        else if (sync_ev || retrig_ev || gate_rise)
            cnt_d = staged_q;
        else if (up_pulse)
            cnt_d = cnt_q + 32'h0000_0001; // R22
        else if (down_pulse)
            cnt_d = cnt_q - 32'h0000_0001; // R22
        if (ld_cnt_q == 3'h1 && ctrl_q.staged_load_request)
            staged_d = ldval_q;
        if (turned_off)
            staged_d = 32'h0000_0000;
        if (aux_rise && (par_q.di_fn == DI_LATCH
                         || par_q.di_fn == DI_LATCH_RT))
            latch_d = cnt_q; // R12
    end

    // Handshakes and flags
    always_comb
    begin
        clr_cnt_d = clr_cnt_q;
        clr_act_d = clr_act_q;
        ld_cnt_d  = ld_cnt_q;
        load_ack_d = load_ack_q;
        if (!ctrl_q.status_clear_request)
        begin
            clr_cnt_d = 3'h0;
            clr_act_d = 1'b0;
        end
        else if (!ctrl_p_q.status_clear_request)
            clr_cnt_d = lat; // R3
        else if (clr_cnt_q != 3'h0)
        begin
            clr_cnt_d = clr_cnt_q - 3'h1;
            clr_act_d = clr_cnt_q == 3'h1; // R19
        end
        if (!(ctrl_q.direct_load_request | ctrl_q.staged_load_request))
        begin
            ld_cnt_d   = 3'h0;
            load_ack_d = 1'b0;
        end
        else if (ld_rise && !load_fault_q)
            ld_cnt_d = lat; // R3
        else if (ld_cnt_q != 3'h0)
        begin
            ld_cnt_d   = ld_cnt_q - 3'h1;
            load_ack_d = ld_cnt_q == 3'h1;
        end
        sync_done_d = sync_ev | (sync_done_q
                      & ~(clr_cnt_q == 3'h1 && ctrl_q.status_clear_request));
        load_fault_d = load_fault_q;
        if (multi_req)
            load_fault_d = 1'b1; // R20
        else if (one_req && ctrl_q[4:0] == 5'h00)
            load_fault_d = 1'b0; // R2
        par_bad = (par_d.gate_inv && par_d.di_fn != DI_HW_GATE)
                  || par_d.eval == 2'b11 || par_d.di_fn > DI_LATCH; // R11
        param_fault_d = par_wr ? par_bad : param_fault_q; // R6
        up_d = up_pulse | (up_q & ~down_pulse);
        dn_d = down_pulse | (dn_q & ~up_pulse);
        diag_d = par_q.group_diag
                 & ((supply_short_flag & ~err_p_q)
                    | (param_fault_q & ~param_fault_d)); // R8
    end

    // Register writes and read mux
    always_comb
    begin
        ctrl_d  = ctrl_wr ? qpf_ctrl_s'(pwdata[CTRL_W-1:0]) : ctrl_q;
        par_d   = par_wr ? qpf_param_s'(pwdata[PARAM_W-1:0]) : par_q;
        ldval_d = (wr_en && paddr == ADDR_LOADV) ? pwdata : ldval_q;
        rd_err  = 1'b0;
        unique case (paddr)
            ADDR_CTRL:   rd_d = {23'h00_0000, ctrl_q};
            ADDR_PARAM:  rd_d = {19'h0_0000, par_q};
            ADDR_LOADV:  rd_d = ldval_q;
            ADDR_COUNT:  rd_d = cnt_q;
            ADDR_LATCH:  rd_d = latch_q;
            ADDR_STATUS: rd_d = {21'h00_0000, load_ack_q, aux_s, gate_p_q,
                                 dn_q, up_q, sync_done_q, clr_act_q,
                                 load_fault_q, param_fault_q,
                                 enc_fault_flag, supply_short_flag};
            default:
            begin
                rd_d   = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_q <= qpf_ctrl_s'(CTRL_RST);
            ctrl_p_q <= qpf_ctrl_s'(CTRL_RST);
            par_q <= qpf_param_s'(PARAM_RST);
            {ldval_q, staged_q, cnt_q, latch_q} <= '0;
            {load_fault_q, param_fault_q, clr_act_q, sync_done_q} <= '0;
            {load_ack_q, up_q, dn_q, gate_p_q, err_p_q} <= '0;
            {a_p_q, b_p_q, aux_p_q, diag_event_q} <= '0;
            {clr_cnt_q, ld_cnt_q} <= '0;
            {pready, pslverr} <= '0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ctrl_q <= ctrl_d;
            ctrl_p_q <= ctrl_q;
            par_q <= par_d;
            ldval_q <= ldval_d;
            staged_q <= staged_d;
            cnt_q <= cnt_d;
            latch_q <= latch_d;
            load_fault_q <= load_fault_d;
            param_fault_q <= param_fault_d;
            clr_act_q <= clr_act_d;
            sync_done_q <= sync_done_d; // R21
            load_ack_q <= load_ack_d;
            up_q <= up_d;
            dn_q <= dn_d;
            gate_p_q <= gate_open;
            err_p_q <= supply_short_flag;
            a_p_q <= a_s;
            b_p_q <= b_s;
            aux_p_q <= aux_s;
            diag_event_q <= diag_d;
            clr_cnt_q <= clr_cnt_d;
            ld_cnt_q <= ld_cnt_d;
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & rd_err;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd_d : prdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !ce);

    sequence clr_start6;
        $rose(ctrl_q.status_clear_request) && par_q.iso_mode
            && par_q.iso_long;
    endsequence
    sequence clr_wait6;
        (!clr_act_q)[*6];
    endsequence

    count_step_a: assert property ( // R22
        up_pulse && !ld_apply && !sync_ev && !retrig_ev && !gate_rise
        |=> cnt_q == $past(cnt_q) + 32'h0000_0001)
        else $error("Up pulse did not increment counter");
    single_blk_a: assert property ( // R15
        par_q.eval == EV_SINGLE && b_s |-> !up_raw && !dn_raw)
        else $error("Single mode counted while B high");
    ldflt_hold_a: assert property ( // R2
        load_fault_q && ctrl_q[4:0] != 5'h00 |=> load_fault_q)
        else $error("Load fault cleared while requests active");
    ldflt_set_a: assert property ( // R20
        multi_req |=> load_fault_q)
        else $error("Multiple requests did not flag load fault");
    pflt_keep_a: assert property ( // R6
        param_fault_q && !par_wr |=> param_fault_q)
        else $error("Parameter fault cleared without new set");
    err_set_a: assert property ( // R4
        sup_s |=> supply_short_flag)
        else $error("Supply fault did not set flag");
    err_track_a: assert property ( // R7
        (ctrl_q.fault_acknowledge || stopped) && !sup_s
        |=> !supply_short_flag)
        else $error("Flag not tracking fault");
    clr_lat_a: assert property (clr_start6 |-> clr_wait6) // R3
        else $error("Status clear answered too early");
    sync_clr_a: assert property ( // R21
        $rose(clr_act_q) && !$past(sync_ev) |-> !sync_done_q)
        else $error("Sync done not cleared by status clear");
    diag_gate_a: assert property ( // R8
        !par_q.group_diag |=> !diag_event_q)
        else $error("Diagnostic event without group diagnostics");

endmodule : qpf_top

// [shared/qpf_pkg.sv]
// Purpose: Shared constants and types for the quadrature position channel
// Assumes: 40 MHz system clock, APB register access, 32-bit data
// Notes:   Register offsets are byte addresses
package qpf_pkg;

    localparam int CLK_HZ       = 40_000_000;
    localparam int TRACK_MAX_HZ = 500_000;
    localparam int CLK_PER_EDGE = CLK_HZ / (4 * TRACK_MAX_HZ);

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PARAM  = 8'h04;
    localparam logic [7:0] ADDR_LOADV  = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_LATCH  = 8'h14;

    localparam int CTRL_W  = 9;
    localparam int PARAM_W = 13;
    localparam int STAT_W  = 11;

    localparam logic [2:0] LAT_PLAIN = 3'h1;
    localparam logic [2:0] LAT_ISO4  = 3'h4;
    localparam logic [2:0] LAT_ISO6  = 3'h6;

    typedef enum logic [1:0] {
        EV_SINGLE = 2'b00,
        EV_DOUBLE = 2'b01,
        EV_QUAD   = 2'b10
    } qpf_eval_e;

    typedef enum logic [2:0] {
        DI_INPUT   = 3'b000,
        DI_HW_GATE = 3'b001,
        DI_LATCH_RT = 3'b010,
        DI_SYNC    = 3'b011,
        DI_SYNC_EN = 3'b100,
        DI_LATCH   = 3'b101
    } qpf_di_e;

    typedef struct packed {
        logic ctrl_stop;
        logic sw_gate;
        logic status_clear_request;
        logic fault_acknowledge;
        logic output_param_change_request;
        logic compare_two_load_request;
        logic compare_one_load_request;
        logic staged_load_request;
        logic direct_load_request;
    } qpf_ctrl_s;

    typedef struct packed {
        logic      iso_long;
        logic      iso_mode;
        logic      group_diag;
        logic      stop_continue;
        logic      sync_periodic;
        qpf_di_e   di_fn;
        logic      gate_inv;
        logic      gate_interrupt;
        logic      dir_invert;
        qpf_eval_e eval;
    } qpf_param_s;

    localparam logic [CTRL_W-1:0]  CTRL_RST  = 9'h000;
    localparam logic [PARAM_W-1:0] PARAM_RST = 13'h0000;

endpackage : qpf_pkg

// [sim/qpf_enc_model.sv]
// Purpose: Incremental encoder model driving tracks A and B
// Assumes: One quarter step per step pulse, stepping paced by the bench
// Notes:   Phase 0..3 maps to AB = 00, 10, 11, 01 going forward
`timescale 1ns/1ps
module qpf_enc_model
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic step,
    input  wire logic dir,
    output logic      enc_a,
    output logic      enc_b
);
    logic [1:0] ph_q;
    logic [1:0] ph_d;

    always_comb
    begin
        ph_d = ph_q;
        if (step)
        begin
            ph_d = dir ? ph_q - 2'd1 : ph_q + 2'd1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ph_q <= 2'd0;
        end
        else
        begin
            ph_q <= ph_d;
        end
    end

    // Tracks 90 degrees apart, one track changes per step
    assign enc_a = (ph_q == 2'd1) || (ph_q == 2'd2);
    assign enc_b = ph_q[1];
endmodule : qpf_enc_model

// [sim/quadrature_position_feedback_bench.sv]
// Purpose: Self-checking bench for the quadrature position channel
// Assumes: APB master tasks, encoder model on the track pins
// Notes:   Table rows cover evaluation modes, direction and stop response
`timescale 1ns/1ps
module quadrature_position_feedback_bench;
    import qpf_pkg::*;
    typedef struct packed {
        logic [15:0] param;
        logic [15:0] ctrl;
        logic        dir;
        logic [31:0] delta;
    } qpf_row_s;
    logic        clk_sys;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        enc_a;
    logic        enc_b;
    logic        aux_in;
    logic        short_in;
    logic        wire_in;
    logic        diag_event_q;
    logic        step;
    logic        dir;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] cnt0;
    int          fails;
    int          n_tests;
    int          n_diag;
    int          k;
    qpf_row_s    rows [9] = '{
        '{16'h0000, 16'h0080, 1'b0, 32'h0000_0002},
        '{16'h0001, 16'h0080, 1'b0, 32'h0000_0004},
        '{16'h0002, 16'h0080, 1'b0, 32'h0000_0008},
        '{16'h0000, 16'h0080, 1'b1, 32'hFFFF_FFFE},
        '{16'h0001, 16'h0080, 1'b1, 32'hFFFF_FFFC},
        '{16'h0002, 16'h0080, 1'b1, 32'hFFFF_FFF8},
        '{16'h0006, 16'h0080, 1'b0, 32'hFFFF_FFF8},
        '{16'h0002, 16'h0180, 1'b0, 32'h0000_0000},
        '{16'h0202, 16'h0180, 1'b0, 32'h0000_0008}
    };

    qpf_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
        .auxiliary_input(aux_in), .supply_short_in(short_in),
        .enc_fault_in(wire_in), .diag_event_q(diag_event_q));

    qpf_enc_model enc_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .step(step), .dir(dir), .enc_a(enc_a), .enc_b(enc_b));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (diag_event_q === 1'b1)
        begin
            n_diag++;
        end
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic stat_bit(input string nm, input int b, input logic e);
        repeat (10) @(posedge clk_sys);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(nm, {31'h0000_0000, rdat[b]}, {31'h0000_0000, e});
    endtask : stat_bit

    task automatic move(input logic d);
        repeat (8)
        begin
            @(posedge clk_sys);
            step <= 1'b1;
            dir  <= d;
            @(posedge clk_sys);
            step <= 1'b0;
            repeat (CLK_PER_EDGE - 2) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
    endtask : move

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; aux_in = 1'b0;
        short_in = 1'b0; wire_in = 1'b0; step = 1'b0; dir = 1'b0;
        fails = 0; n_tests = 0; n_diag = 0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_PARAM, 32'h0000_0000);
        chk("param reset", rdat, 32'h0000_0000);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("status reset", rdat & 32'h0000_003F, 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped", {rdat[30:0], rerr}, 32'h0000_0001);
        foreach (rows[i])
        begin
            apb(1'b1, ADDR_PARAM, {16'h0000, rows[i].param});
            apb(1'b1, ADDR_CTRL, {16'h0000, rows[i].ctrl});
            apb(1'b0, ADDR_COUNT, 32'h0000_0000);
            cnt0 = rdat;
            move(rows[i].dir);
            apb(1'b0, ADDR_COUNT, 32'h0000_0000);
            chk("count", rdat, cnt0 + rows[i].delta);
        end
        apb(1'b1, ADDR_PARAM, 32'h0000_0000);
        apb(1'b1, ADDR_LOADV, 32'h0000_1234);
        apb(1'b1, ADDR_CTRL, 32'h0000_0083);
        stat_bit("load fault", 3, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0081);
        stat_bit("load fault", 3, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0080);
        stat_bit("load fault", 3, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0081);
        stat_bit("load fault", 3, 1'b0);
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        chk("load", rdat, 32'h0000_1234);
        apb(1'b1, ADDR_CTRL, 32'h0000_0080);
        apb(1'b1, ADDR_PARAM, 32'h0000_0010);
        stat_bit("param fault", 2, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_00A0);
        stat_bit("param fault", 2, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0080);
        apb(1'b1, ADDR_PARAM, 32'h0000_0030);
        stat_bit("param fault", 2, 1'b0);
        apb(1'b1, ADDR_PARAM, 32'h0000_0000);
        short_in <= 1'b1;
        wire_in  <= 1'b1;
        stat_bit("wire flag", 1, 1'b1);
        short_in <= 1'b0;
        wire_in  <= 1'b0;
        stat_bit("short flag", 0, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_00A0);
        stat_bit("short flag", 0, 1'b0);
        short_in <= 1'b1;
        stat_bit("short flag", 0, 1'b1);
        short_in <= 1'b0;
        stat_bit("short flag", 0, 1'b0);
        chk("diag off", n_diag, 32'h0000_0000);
        apb(1'b1, ADDR_PARAM, 32'h0000_0400);
        short_in <= 1'b1;
        stat_bit("short flag", 0, 1'b1);
        chk("diag on", n_diag, 32'h0000_0001);
        short_in <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h0000_0080);
        apb(1'b1, ADDR_PARAM, 32'h0000_0060);
        aux_in <= 1'b1;
        stat_bit("sync done", 5, 1'b1);
        aux_in <= 1'b0;
        apb(1'b1, ADDR_PARAM, 32'h0000_1860);
        apb(1'b1, ADDR_CTRL, 32'h0000_00C0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("clear early", {31'h0000_0000, rdat[4]}, 32'h0000_0000);
        k = 0;
        while (rdat[4] !== 1'b1 && k < 10)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            k++;
        end
        chk("clear active", {31'h0000_0000, rdat[4]}, 32'h0000_0001);
        chk("sync cleared", {31'h0000_0000, rdat[5]}, 32'h0000_0000);
        apb(1'b1, ADDR_CTRL, 32'h0000_0080);
        stat_bit("clear active", 4, 1'b0);
        apb(1'b1, ADDR_PARAM, 32'h0000_00A0);
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        cnt0 = rdat;
        move(1'b0);
        aux_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        apb(1'b0, ADDR_LATCH, 32'h0000_0000);
        chk("latch", rdat, cnt0 + 32'h0000_0002);
        aux_in <= 1'b0;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_PARAM, 32'h0000_0000);
        chk("param rerun", rdat, 32'h0000_0000);
        apb(1'b0, ADDR_COUNT, 32'h0000_0000);
        chk("count rerun", rdat, 32'h0000_0000);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("status rerun", rdat, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : quadrature_position_feedback_bench
